// ### hw/misc_regs_pkg.sv
// Functional notes
// - one-shot request starts single measurement when period zero
// - one-shot request ignored during sleep mode
// - hardware clears one-shot bit when measurement finishes
// - six-bit selector, low five bits pick first test mux signal
// - five-bit selector picks second test mux signal
// - three remote sensor selects, zero on reset/wake
// - read-only revision index returns fixed code
// - reference output enable gated off by disable
// - reference disable: zero at reset, one on wake
// - read-only supply-state code reports power state
// - code 011 inhibits flash, fuse clears pll fast
// - wake timer runs field plus one seconds
// - writing one restarts and clears watchdog count
// - period field: none, 2^(3+n) seconds, continuous
package misc_regs_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [15:0] SUPPLY_STATE_OFS   = 16'h00F9;
    localparam logic [15:0] TEST_MUX_OFS       = 16'h2502;
    localparam logic [15:0] SECOND_MUX_OFS     = 16'h2503;
    localparam logic [15:0] REFERENCE_OFS      = 16'h2704;
    localparam logic [15:0] REVISION_OFS       = 16'h2706;
    localparam logic [15:0] REMOTE_C_OFS       = 16'h2709;
    localparam logic [15:0] REMOTE_AB_OFS      = 16'h270A;
    localparam logic [15:0] WAKE_TIMER_OFS     = 16'h2880;
    localparam logic [15:0] TEMP_PERIOD_OFS    = 16'h28A0;
    localparam logic [15:0] TEMP_WDOG_OFS      = 16'h28B4;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int REF_OUT_EN_BIT   = 7;
    localparam int REF_DIS_BIT      = 6;
    localparam int REMOTE_B_LSB     = 4;
    localparam int WDOG_RESTART_BIT = 7;
    localparam int TEMP_ONESHOT_BIT = 6;
    // ************************************************************
    // reset and wake values
    // ************************************************************
    localparam logic [5:0] TEST_MUX_RST    = 6'h00;
    localparam logic [4:0] SECOND_MUX_RST  = 5'h00;
    localparam logic [2:0] REMOTE_RST      = 3'h0;
    localparam logic       REF_DIS_RST     = 1'b0;
    localparam logic       REF_DIS_WAKE    = 1'b1;
    localparam logic [7:0] WAKE_TIMER_RST  = 8'h00;
    localparam logic [2:0] TEMP_PERIOD_RST = 3'h0;
    localparam logic [2:0] SUPPLY_MARGINAL = 3'h3;
    localparam logic [2:0] TEMP_CONTINUOUS = 3'h7;
    localparam int TEMP_EXP_BASE           = 3;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ          = 250_000_000;
    localparam int SECOND_CYCLES   = CLK_HZ;

    typedef struct packed {
        logic [5:0] test_mux;
        logic [4:0] second_mux;
        logic [2:0] remote_a;
        logic [2:0] remote_b;
        logic [2:0] remote_c;
    } mux_cfg_s;

    typedef enum logic [1:0] {
        temp_idle,
        temp_busy
    } temp_state_e;
endpackage : misc_regs_pkg

// ### hw/misc_control_status_regs.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module misc_control_status_regs
    import misc_regs_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5A, // arbitrary value
    parameter int         SECOND_LEN    = SECOND_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    input  wire logic        sleep_mode_in,
    input  wire logic        wake_event_in,
    input  wire logic [2:0]  supply_state_code_in,
    input  wire logic        supply_trim_fuse_in,
    input  wire logic        temp_done_in,
    input  wire logic [31:0] mux_sources_in,
    input  wire logic [31:0] second_mux_sources_in,
    output logic             temp_start_out,
    output logic             test_mux_output_out,
    output logic             second_test_mux_output_out,
    output mux_cfg_s         mux_cfg_out,
    output logic             reference_output_enable_out,
    output logic             reference_disable_out,
    output logic             flash_write_inhibit_out,
    output logic             pll_fast_clear_out,
    output logic             wdog_restart_out,
    output logic             wake_timer_expired_out
);
    // ************************************************************
    // pin synchroniser for supply and sleep levels
    // ************************************************************
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] stable_r;
    logic [3:0] pins_raw;
    assign pins_raw = {sleep_mode_in, supply_state_code_in};

    // change accepted only when the two later stages agree
    always_ff @(posedge clk_in) begin
        sync1_r <= pins_raw;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        if (sys_rst_in) begin
            stable_r <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    stable_r[i] <= sync3_r[i];
                end
            end
        end
    end

    logic       sleep_s;
    logic [2:0] supply_s;
    assign sleep_s  = stable_r[3];
    assign supply_s = stable_r[2:0];

    // ************************************************************
    // registers
    // ************************************************************
    mux_cfg_s    cfg_r;
    logic        ref_out_en_r;
    logic        ref_dis_r;
    logic [7:0]  wake_dur_r;
    logic [2:0]  temp_per_r;
    logic        oneshot_r;
    logic        wdog_r;
    temp_state_e temp_st_r;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        return a == o;
    endfunction : hit

    wire wr_mux   = wr_in && hit(addr_in, TEST_MUX_OFS);
    wire wr_mux2  = wr_in && hit(addr_in, SECOND_MUX_OFS);
    wire wr_ref   = wr_in && hit(addr_in, REFERENCE_OFS);
    wire wr_rc    = wr_in && hit(addr_in, REMOTE_C_OFS);
    wire wr_rab   = wr_in && hit(addr_in, REMOTE_AB_OFS);
    wire wr_wake  = wr_in && hit(addr_in, WAKE_TIMER_OFS);
    wire wr_per   = wr_in && hit(addr_in, TEMP_PERIOD_OFS);
    wire wr_tw    = wr_in && hit(addr_in, TEMP_WDOG_OFS);
    // one-shot only honoured when idle, awake, no automatic period
    wire oneshot_go = wr_tw && wdata_in[TEMP_ONESHOT_BIT]
                      && (temp_per_r == 3'h0)
                      && !sleep_s;

    // configuration write and wake handling
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cfg_r        <= '{TEST_MUX_RST, SECOND_MUX_RST,
                              REMOTE_RST, REMOTE_RST, REMOTE_RST};
            ref_out_en_r <= 1'b0;
            ref_dis_r    <= REF_DIS_RST;
            wake_dur_r   <= WAKE_TIMER_RST;
            temp_per_r   <= TEMP_PERIOD_RST;
        end else if (wake_event_in) begin
            cfg_r.remote_a <= REMOTE_RST;
            cfg_r.remote_b <= REMOTE_RST;
            cfg_r.remote_c <= REMOTE_RST;
            ref_out_en_r   <= 1'b0;
            ref_dis_r      <= REF_DIS_WAKE;
        end else begin
            if (wr_mux) cfg_r.test_mux <= wdata_in[5:0];
            if (wr_mux2) cfg_r.second_mux <= wdata_in[4:0];
            if (wr_rab) begin
                cfg_r.remote_a <= wdata_in[2:0];
                cfg_r.remote_b <= wdata_in[REMOTE_B_LSB +: 3];
            end
            if (wr_rc) cfg_r.remote_c <= wdata_in[2:0];
            if (wr_ref) begin
                ref_out_en_r <= wdata_in[REF_OUT_EN_BIT];
                ref_dis_r    <= wdata_in[REF_DIS_BIT];
            end
            if (wr_wake) wake_dur_r <= wdata_in;
            if (wr_per) temp_per_r <= wdata_in[2:0];
        end
    end

    // ************************************************************
    // temperature request sequencing
    // ************************************************************
    // done wins only when busy; a new request needs idle first
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || wake_event_in) begin
            oneshot_r <= 1'b0;
            temp_st_r <= temp_idle;
        end else begin
            unique case (temp_st_r)
                temp_idle: begin
                    if (oneshot_go) begin
                        oneshot_r <= 1'b1;
                        temp_st_r <= temp_busy;
                    end
                end
                temp_busy: begin
                    if (temp_done_in) begin
                        oneshot_r <= 1'b0;
                        temp_st_r <= temp_idle;
                    end
                end
                default: temp_st_r <= temp_idle;
            endcase
        end
    end

    // ************************************************************
    // automatic measurement period
    // ************************************************************
    logic [31:0] sec_cnt_r;
    logic [9:0]  per_sec_r;
    logic        sec_tick;
    logic        auto_start;
    logic [9:0]  per_len;
    assign sec_tick = (sec_cnt_r == 32'(SECOND_LEN - 1));
    assign per_len  = 10'(1) << (TEMP_EXP_BASE + temp_per_r);
    assign auto_start = (temp_per_r == TEMP_CONTINUOUS) ||
                        ((temp_per_r != 3'h0) && sec_tick &&
                         (per_sec_r == per_len - 10'h1));

    // second divider shared by period and wake timers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || sec_tick) sec_cnt_r <= 32'h0;
        else sec_cnt_r <= sec_cnt_r + 32'h1;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || wr_per) per_sec_r <= 10'h0;
        else if (sec_tick) begin
            per_sec_r <= (per_sec_r == per_len - 10'h1) ? 10'h0
                                                         : per_sec_r + 10'h1;
        end
    end

    // ************************************************************
    // wake timer and watchdog restart
    // ************************************************************
    logic [8:0] wake_cnt_r;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !sleep_s) begin
            wake_cnt_r             <= 9'h0;
            wake_timer_expired_out <= 1'b0;
        end else if (sec_tick) begin
            // count one extra tick: the first second may be partial,
            // so expiry never comes before field plus one full seconds
            if (wake_cnt_r == {1'b0, wake_dur_r} + 9'h1) begin
                wake_timer_expired_out <= 1'b1;
            end else begin
                wake_cnt_r <= wake_cnt_r + 9'h1;
            end
        end
    end

    // writing zero leaves the watchdog untouched
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) wdog_r <= 1'b0;
        else wdog_r <= wr_tw && wdata_in[WDOG_RESTART_BIT];
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic tm_r;
    logic tm2_r;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tm_r  <= 1'b0;
            tm2_r <= 1'b0;
        end else begin
            tm_r  <= mux_sources_in[cfg_r.test_mux[4:0]];
            tm2_r <= second_mux_sources_in[cfg_r.second_mux];
        end
    end

    assign test_mux_output_out        = tm_r;
    assign second_test_mux_output_out = tm2_r;
    assign mux_cfg_out                = cfg_r;
    assign temp_start_out   = oneshot_r || auto_start;
    assign reference_output_enable_out = ref_out_en_r && !ref_dis_r;
    assign reference_disable_out       = ref_dis_r;
    assign flash_write_inhibit_out = (supply_s == SUPPLY_MARGINAL);
    assign pll_fast_clear_out = flash_write_inhibit_out
                                && supply_trim_fuse_in;
    assign wdog_restart_out   = wdog_r;

    // ************************************************************
    // read data, one cycle after the strobe
    // ************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (addr_in)
            SUPPLY_STATE_OFS: rd_mux = {5'h00, supply_s};
            TEST_MUX_OFS:     rd_mux = {2'h0, cfg_r.test_mux};
            SECOND_MUX_OFS:   rd_mux = {3'h0, cfg_r.second_mux};
            REFERENCE_OFS:    rd_mux = {ref_out_en_r, ref_dis_r, 6'h00};
            REVISION_OFS:     rd_mux = REVISION_CODE;
            REMOTE_C_OFS:     rd_mux = {5'h00, cfg_r.remote_c};
            REMOTE_AB_OFS:    rd_mux = {1'b0, cfg_r.remote_b,
                                        1'b0, cfg_r.remote_a};
            WAKE_TIMER_OFS:   rd_mux = wake_dur_r;
            TEMP_PERIOD_OFS:  rd_mux = {5'h00, temp_per_r};
            TEMP_WDOG_OFS:    rd_mux = {1'b0, oneshot_r, 6'h00};
            default:          rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !rd_in) rdata_out <= 8'h00;
        else rdata_out <= rd_mux;
    end
endmodule : misc_control_status_regs
`default_nettype wire

// ### test/misc_control_status_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module misc_control_status_regs_checker
    import misc_regs_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5A
) (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic        sleep_mode_in,
    input wire logic        wake_event_in,
    input wire logic        temp_done_in,
    input wire logic [31:0] mux_sources_in,
    input wire logic        temp_start_out,
    input wire logic        test_mux_output_out,
    input wire mux_cfg_s    mux_cfg_out,
    input wire logic        reference_output_enable_out,
    input wire logic        reference_disable_out,
    input wire logic        wdog_restart_out
);
    // ************************************************************
    // bus-side checks
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [2:0] period_r;
    wire        wr_tw = wr_in && addr_in == TEMP_WDOG_OFS;
    // shadow of the auto period, the one-shot only counts when it is zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) period_r <= TEMP_PERIOD_RST;
        else if (wr_in && addr_in == TEMP_PERIOD_OFS) period_r <= wdata_in[2:0];
    end
    property p_wdog_pulse;
        wr_tw && wdata_in[WDOG_RESTART_BIT] |=> wdog_restart_out;
    endproperty
    a_wdog_pulse: assert property (p_wdog_pulse) else $error("no restart");
    property p_rdata_idle;
        !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray rdata");
    property p_revision;
        rd_in && addr_in == REVISION_OFS |=> rdata_out == REVISION_CODE;
    endproperty
    a_revision: assert property (p_revision) else $error("bad revision");
    property p_ref_wake;
        wake_event_in |=> reference_disable_out && !reference_output_enable_out
            && mux_cfg_out.remote_a == 3'h0 && mux_cfg_out.remote_c == 3'h0;
    endproperty
    a_ref_wake: assert property (p_ref_wake) else $error("wake values");
    // sleep must have been low long enough to pass the pin synchroniser
    property p_oneshot_start;
        (!sleep_mode_in)[*5] ##0 (wr_tw && wdata_in[TEMP_ONESHOT_BIT]
            && period_r == 3'h0 && !wake_event_in) |=> temp_start_out;
    endproperty
    a_oneshot_start: assert property (p_oneshot_start) else $error("no start");
    property p_oneshot_hold;
        temp_start_out && !temp_done_in && !wake_event_in && !sleep_mode_in
            && period_r == 3'h0 && $past(period_r, 2) == 3'h0
            |=> temp_start_out;
    endproperty
    a_oneshot_hold: assert property (p_oneshot_hold) else $error("dropped");
    property p_oneshot_done;
        temp_start_out && temp_done_in && period_r == 3'h0 |=> !temp_start_out;
    endproperty
    a_oneshot_done: assert property (p_oneshot_done) else $error("not cleared");
    property p_mux_route;
        !$past(sys_rst_in) |->
            test_mux_output_out == $past(mux_sources_in[mux_cfg_out.test_mux[4:0]]);
    endproperty
    a_mux_route: assert property (p_mux_route) else $error("mux route");
    c_oneshot: cover property (wr_tw ##1 temp_start_out);
    c_wake: cover property (wake_event_in);
    c_wdog: cover property (wdog_restart_out);
endmodule : misc_control_status_regs_checker
bind misc_control_status_regs misc_control_status_regs_checker
    #(.REVISION_CODE(REVISION_CODE)) u_chk (.clk_in, .sys_rst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .sleep_mode_in, .wake_event_in,
    .temp_done_in, .mux_sources_in, .temp_start_out, .test_mux_output_out,
    .mux_cfg_out, .reference_output_enable_out, .reference_disable_out,
    .wdog_restart_out);
`default_nettype wire

// ### test/misc_control_status_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module misc_control_status_regs_tb
    import misc_regs_pkg::*;
;
    // ************************************************************
    // bench
    // ************************************************************
    localparam logic [7:0] REV = 8'hC3; // arbitrary value
    localparam int         SEC = 8;     // short second keeps the run brief
    logic        clk_in, sys_rst_in, wr_in, rd_in, sleep_mode_in, wake_event_in;
    logic        supply_trim_fuse_in, temp_done_in, temp_start_out;
    logic        test_mux_output_out, second_test_mux_output_out;
    logic        reference_output_enable_out, reference_disable_out;
    logic        flash_write_inhibit_out, pll_fast_clear_out;
    logic        wdog_restart_out, wake_timer_expired_out;
    logic [15:0] addr_in, rnd, a;
    logic [7:0]  wdata_in, rdata_out;
    logic [2:0]  supply_state_code_in;
    logic [31:0] mux_sources_in, second_mux_sources_in;
    mux_cfg_s    mux_cfg_out;
    int          fail_count, n_compared, i, k;
    misc_control_status_regs #(.REVISION_CODE(REV), .SECOND_LEN(SEC)) u_dut (
        .clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .sleep_mode_in, .wake_event_in, .supply_state_code_in,
        .supply_trim_fuse_in, .temp_done_in, .mux_sources_in,
        .second_mux_sources_in, .temp_start_out, .test_mux_output_out,
        .second_test_mux_output_out, .mux_cfg_out,
        .reference_output_enable_out, .reference_disable_out,
        .flash_write_inhibit_out, .pll_fast_clear_out, .wdog_restart_out,
        .wake_timer_expired_out);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // implemented bits of each register the random loop writes
    function automatic logic [7:0] rw_mask(input logic [15:0] ofs);
        case (ofs)
            TEST_MUX_OFS:  return 8'h3F;
            SECOND_MUX_OFS: return 8'h1F;
            REMOTE_AB_OFS: return 8'h77;
            REMOTE_C_OFS:  return 8'h07;
            default:       return 8'hFF;
        endcase
    endfunction : rw_mask
    task automatic wrap_up;
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= ofs; wdata_in <= d; wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] ofs, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= ofs; rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out === e, "read data");
    endtask : rd
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {wr_in, rd_in, sleep_mode_in, wake_event_in, temp_done_in} = '0;
        {addr_in, wdata_in, supply_state_code_in, supply_trim_fuse_in} = '0;
        {mux_sources_in, second_mux_sources_in} = '0;
        fail_count = 0; n_compared = 0; rnd = 16'h6A57; sys_rst_in = 1'b1;
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(REMOTE_AB_OFS, 8'h00); rd(REMOTE_C_OFS, 8'h00);
        rd(REFERENCE_OFS, 8'h00); rd(WAKE_TIMER_OFS, 8'h00);
        rd(TEMP_WDOG_OFS, 8'h00); rd(16'h2705, 8'h00);
        wr(REVISION_OFS, 8'hFF); rd(REVISION_OFS, REV);
        for (i = 0; i < 30; i++) begin
            rnd = lfsr(rnd);
            case (rnd[2:0] % 5)
                0: a = TEST_MUX_OFS;  1: a = SECOND_MUX_OFS;
                2: a = REMOTE_AB_OFS; 3: a = REMOTE_C_OFS;
                default: a = WAKE_TIMER_OFS;
            endcase
            wr(a, rnd[15:8]); rd(a, rnd[15:8] & rw_mask(a));
            @(posedge clk_in);
            mux_sources_in <= {rnd, lfsr(rnd)};
            step(2);
            chk(test_mux_output_out === mux_sources_in[mux_cfg_out.test_mux[4:0]],
                "first mux");
        end
        for (k = 0; k < 4; k++) begin
            wr(REFERENCE_OFS, 8'(k << 6));
            chk(reference_output_enable_out === (k == 2), "ref out");
            chk(reference_disable_out === k[0], "ref disable");
        end
        wr(TEMP_WDOG_OFS, 8'h40); chk(temp_start_out === 1'b1, "start");
        rd(TEMP_WDOG_OFS, 8'h40);
        @(posedge clk_in); temp_done_in <= 1'b1;
        @(posedge clk_in); temp_done_in <= 1'b0;
        step(0); chk(temp_start_out === 1'b0, "not cleared");
        rd(TEMP_WDOG_OFS, 8'h00);
        wr(WAKE_TIMER_OFS, 8'h02);
        @(posedge clk_in); sleep_mode_in <= 1'b1;
        for (k = 0; k < 100 && wake_timer_expired_out !== 1'b1; k++) step(1);
        chk(k >= 3 * SEC && k <= 4 * SEC + 4, "wake span");
        wr(TEMP_WDOG_OFS, 8'h40); step(2);
        chk(temp_start_out === 1'b0, "start in sleep");
        @(posedge clk_in); sleep_mode_in <= 1'b0;
        step(6); chk(wake_timer_expired_out === 1'b0, "wake stuck");
        wr(TEMP_PERIOD_OFS, 8'h07); step(3);
        chk(temp_start_out === 1'b1, "continuous");
        wr(TEMP_PERIOD_OFS, 8'h03); step(3); wr(TEMP_WDOG_OFS, 8'h40); step(2);
        chk(temp_start_out === 1'b0, "extra start");
        wr(TEMP_PERIOD_OFS, 8'h00); step(3);
        wr(TEMP_WDOG_OFS, 8'h80); chk(wdog_restart_out === 1'b1, "wdog");
        step(1); chk(wdog_restart_out === 1'b0, "wdog long");
        wr(TEMP_WDOG_OFS, 8'h00); chk(wdog_restart_out === 1'b0, "wdog 0");
        wr(REMOTE_AB_OFS, 8'h77); wr(REMOTE_C_OFS, 8'h07); wr(REFERENCE_OFS, 8'h80);
        @(posedge clk_in); wake_event_in <= 1'b1;
        @(posedge clk_in); wake_event_in <= 1'b0;
        rd(REMOTE_AB_OFS, 8'h00); rd(REMOTE_C_OFS, 8'h00);
        rd(REFERENCE_OFS, 8'h40);
        for (k = 0; k < 16; k++) begin
            @(posedge clk_in);
            supply_state_code_in <= k[2:0]; supply_trim_fuse_in <= k[3];
            step(6); rd(SUPPLY_STATE_OFS, 8'(k[2:0]));
            chk(flash_write_inhibit_out === (k[2:0] == 3), "flash");
            chk(pll_fast_clear_out === (k[2:0] == 3 && k[3]), "pll");
        end
        wrap_up();
    end
endmodule : misc_control_status_regs_tb
`default_nettype wire
